// ===== shared/lcs_pkg.sv
// constants and types for the lcd setup and shutdown command interpreter
// Function
// R1: command 3AH is taken as the interface pixel format command that sets the grayscale depth of incoming pixels.
// R2: command 2DH is taken as the colour set command that fills the colour table used in 256-colour mode.
// R3: command 36H is taken as the memory access control command that sets how display memory is traversed.
// R4: command 2BH sets the page range and command 2AH sets the column range of the memory window.
// R5: after command 2CH the following data bytes are written into display memory inside the window.
// R6: the host sends display on (29H) after setup, and may order the other setup commands freely; the bench sends 3AH and 36H again after display on.
// R7: the host may skip any setup command whose reset value already suits it.
// R8: a host shutting down without reset sends display off (28H), then sleep in (10H), then removes power.
// R9: on sleep in the device enters sleep and stops its lcd supply so the capacitors can discharge.
// R10: a host shutting down with reset drives the active-low init line low before removing power.
// R11: the host should periodically resend configuration and display data to undo noise damage; the host model never resends periodically.
// R12: the host holds the active-low init line low for at least the minimum reset pulse width.
// R13: the host finishes each command and its parameters before starting the next command.
// R14: the host waits a configurable delay after sleep in before signalling that power may go.
package lcs_pkg;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_SLEEP_IN  = 8'h10;
  localparam logic [7:0] CMD_SLEEP_OUT = 8'h11;
  localparam logic [7:0] CMD_DISP_OFF  = 8'h28;
  localparam logic [7:0] CMD_DISP_ON   = 8'h29;
  localparam logic [7:0] CMD_COL_ADDR  = 8'h2A;
  localparam logic [7:0] CMD_PAGE_ADDR = 8'h2B;
  localparam logic [7:0] CMD_MEM_WR    = 8'h2C;
  localparam logic [7:0] CMD_CLR_SET   = 8'h2D;
  localparam logic [7:0] CMD_MEM_ACC   = 8'h36;
  localparam logic [7:0] CMD_PIX_FMT   = 8'h3A;

  // ----------------------------------------------------------------
  // parameter counts and reset values
  // ----------------------------------------------------------------
  localparam int         CLR_SET_LEN   = 20;
  localparam logic [4:0] PCNT_ONE      = 5'h01;
  localparam logic [4:0] PCNT_TWO      = 5'h02;
  localparam logic [4:0] PCNT_CLR      = 5'h14;
  localparam logic [7:0] PIX_FMT_RST   = 8'h03;
  localparam logic [7:0] MEM_ACC_RST   = 8'h00;
  localparam logic [7:0] CLR_ENTRY_RST = 8'h00;
  localparam logic [7:0] PAGE_END_RST  = 8'h53;
  localparam logic [7:0] COL_END_RST   = 8'h67;
  localparam logic [7:0] ADDR_ZERO     = 8'h00;

  // ----------------------------------------------------------------
  // interpreter states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_PARAM = 3'b010,
    ST_MWR   = 3'b100
  } lcs_state_e;

endpackage

// ===== verilog/lcs_pair_buf.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module lcs_pair_buf #(
  parameter int WIDTH = 24
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  logic [WIDTH-1:0] slot_r [2];
  logic             wr_ptr_r;
  logic             rd_ptr_r;
  logic [1:0]       count_r;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != 2'h2);
  assign out_valid = (count_r != 2'h0);
  assign out_data  = slot_r[rd_ptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      slot_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      case ({push, pop})
        2'b10:   count_r <= count_r + 2'h1;
        2'b01:   count_r <= count_r - 2'h1;
        default: count_r <= count_r;
      endcase
    end
  end

endmodule

// ===== verilog/lcs_cmd_interp.sv
// command interpreter for lcd setup, memory write and sleep shutdown
`timescale 1ns/1ps
module lcs_cmd_interp
  import lcs_pkg::*;
(
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic       CHIP_INIT_LINE_N,
  // host byte port
  input  wire logic       IN_VALID,
  output logic            IN_READY,
  input  wire logic       IN_DC,
  input  wire logic [7:0] IN_BYTE,
  // display memory write stream
  output logic            MEM_VALID,
  input  wire logic       MEM_READY,
  output logic [7:0]      MEM_PAGE,
  output logic [7:0]      MEM_COL,
  output logic [7:0]      MEM_DATA,
  // configuration state
  output logic [7:0]      PIX_FMT,
  output logic [7:0]      MEM_ACC,
  input  wire logic [4:0] CLR_RD_IDX,
  output logic [7:0]      CLR_RD_DATA,
  // display and power state
  output logic            DISP_ON,
  output logic            SLEEP_ST,
  output logic            LCD_SUPPLY_EN
);

  // ----------------------------------------------------------------
  // decoding
  // ----------------------------------------------------------------
  function automatic logic [4:0] param_count(input logic [7:0] code);
    case (code)
      CMD_PIX_FMT:   param_count = PCNT_ONE;
      CMD_MEM_ACC:   param_count = PCNT_ONE;
      CMD_PAGE_ADDR: param_count = PCNT_TWO;
      CMD_COL_ADDR:  param_count = PCNT_TWO;
      CMD_CLR_SET:   param_count = PCNT_CLR;
      default:       param_count = 5'h00;
    endcase
  endfunction

  lcs_state_e state_r;
  logic [7:0] cmd_r;
  logic [4:0] pcnt_r;
  logic [7:0] pix_fmt_r;
  logic [7:0] mem_acc_r;
  logic [7:0] page_start_r;
  logic [7:0] page_end_r;
  logic [7:0] col_start_r;
  logic [7:0] col_end_r;
  logic [7:0] page_r;
  logic [7:0] col_r;
  logic [7:0] clr_tab_r [CLR_SET_LEN];
  logic [7:0] clr_rd_r;
  logic       disp_on_r;
  logic       sleep_r;
  logic       supply_en_r;
  logic       init;
  logic       buf_in_ready;
  logic       buf_in_valid;
  logic       cmd_take;
  logic       par_take;
  logic       dat_take;

  // the init line is sampled as a plain synchronous input
  assign init      = RST || !CHIP_INIT_LINE_N;
  // commands are never stalled; only memory data waits on the buffer
  assign IN_READY  = (state_r == ST_MWR && IN_DC) ? buf_in_ready : 1'b1;
  assign cmd_take  = IN_VALID && IN_READY && !IN_DC;
  assign par_take  = IN_VALID && IN_READY && IN_DC && (state_r == ST_PARAM);
  assign dat_take  = IN_VALID && IN_READY && IN_DC && (state_r == ST_MWR);
  assign buf_in_valid = IN_VALID && IN_DC && (state_r == ST_MWR);

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (init) begin
      state_r <= ST_IDLE;
      cmd_r   <= 8'h00;
      pcnt_r  <= 5'h00;
    end else if (cmd_take) begin
      cmd_r  <= IN_BYTE;
      pcnt_r <= 5'h00;
      if (param_count(IN_BYTE) != 5'h00) begin
        state_r <= ST_PARAM;
      end else if (IN_BYTE == CMD_MEM_WR) begin
        state_r <= ST_MWR; // R5
      end else begin
        state_r <= ST_IDLE;
      end
    end else if (par_take) begin
      pcnt_r <= pcnt_r + 5'h01;
      case (state_r)
        ST_PARAM: begin
          if (pcnt_r == param_count(cmd_r) - 5'h01) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // configuration parameters
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (init) begin
      pix_fmt_r <= PIX_FMT_RST;
    end else if (par_take && cmd_r == CMD_PIX_FMT) begin
      pix_fmt_r <= IN_BYTE; // R1
    end
  end

  always_ff @(posedge CLK) begin
    if (init) begin
      mem_acc_r <= MEM_ACC_RST;
    end else if (par_take && cmd_r == CMD_MEM_ACC) begin
      mem_acc_r <= IN_BYTE; // R3
    end
  end

  always_ff @(posedge CLK) begin
    if (init) begin
      page_start_r <= ADDR_ZERO;
      page_end_r   <= PAGE_END_RST;
      col_start_r  <= ADDR_ZERO;
      col_end_r    <= COL_END_RST;
    end else if (par_take) begin
      if (cmd_r == CMD_PAGE_ADDR) begin
        if (pcnt_r == 5'h00) page_start_r <= IN_BYTE; // R4
        else page_end_r <= IN_BYTE; // R4
      end
      if (cmd_r == CMD_COL_ADDR) begin
        if (pcnt_r == 5'h00) col_start_r <= IN_BYTE; // R4
        else col_end_r <= IN_BYTE; // R4
      end
    end
  end

  generate
    for (genvar i = 0; i < CLR_SET_LEN; i++) begin : g_clr
      always_ff @(posedge CLK) begin
        if (init) begin
          clr_tab_r[i] <= CLR_ENTRY_RST;
        end else if (par_take && cmd_r == CMD_CLR_SET && pcnt_r == 5'(i)) begin
          clr_tab_r[i] <= IN_BYTE; // R2
        end
      end
    end
  endgenerate

  // out-of-range read index returns zero
  always_ff @(posedge CLK) begin
    if (init) begin
      clr_rd_r <= 8'h00;
    end else if (CLR_RD_IDX < 5'(CLR_SET_LEN)) begin
      clr_rd_r <= clr_tab_r[CLR_RD_IDX];
    end else begin
      clr_rd_r <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // memory write address walk
  // ----------------------------------------------------------------
  // column runs first, then page; the window wraps to its start corner
  always_ff @(posedge CLK) begin
    if (init) begin
      page_r <= ADDR_ZERO;
      col_r  <= ADDR_ZERO;
    end else if (cmd_take && IN_BYTE == CMD_MEM_WR) begin
      page_r <= page_start_r; // R5
      col_r  <= col_start_r;
    end else if (dat_take) begin
      if (col_r == col_end_r) begin
        col_r  <= col_start_r; // R5
        page_r <= (page_r == page_end_r) ? page_start_r : page_r + 8'h01;
      end else begin
        col_r <= col_r + 8'h01;
      end
    end
  end

  lcs_pair_buf #(.WIDTH(24)) u_buf (
    .clk       (CLK),
    .rst       (init),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   ({page_r, col_r, IN_BYTE}),
    .out_valid (MEM_VALID),
    .out_ready (MEM_READY),
    .out_data  ({MEM_PAGE, MEM_COL, MEM_DATA})
  );

  // ----------------------------------------------------------------
  // display and sleep
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (init) begin
      disp_on_r <= 1'b0;
    end else if (cmd_take && IN_BYTE == CMD_DISP_ON) begin
      disp_on_r <= 1'b1;
    end else if (cmd_take && IN_BYTE == CMD_DISP_OFF) begin
      disp_on_r <= 1'b0;
    end
  end

  // reset leaves the device asleep with the supply stopped
  always_ff @(posedge CLK) begin
    if (init) begin
      sleep_r     <= 1'b1;
      supply_en_r <= 1'b0;
    end else if (cmd_take && IN_BYTE == CMD_SLEEP_IN) begin
      sleep_r     <= 1'b1; // R9
      supply_en_r <= 1'b0; // R9
    end else if (cmd_take && IN_BYTE == CMD_SLEEP_OUT) begin
      sleep_r     <= 1'b0;
      supply_en_r <= 1'b1;
    end
  end

  assign PIX_FMT       = pix_fmt_r;
  assign MEM_ACC       = mem_acc_r;
  assign CLR_RD_DATA   = clr_rd_r;
  assign DISP_ON       = disp_on_r;
  assign SLEEP_ST      = sleep_r;
  assign LCD_SUPPLY_EN = supply_en_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  property p_pix_fmt;
    par_take && cmd_r == CMD_PIX_FMT && CHIP_INIT_LINE_N |=> PIX_FMT == $past(IN_BYTE) && state_r == ST_IDLE;
  endproperty
  a_pix_fmt: assert property (p_pix_fmt) else $error("pixel format not stored"); // R1

  property p_clr_set;
    par_take && cmd_r == CMD_CLR_SET && CHIP_INIT_LINE_N |=> clr_tab_r[$past(pcnt_r)] == $past(IN_BYTE);
  endproperty
  a_clr_set: assert property (p_clr_set) else $error("colour entry not stored"); // R2

  property p_mem_acc;
    cmd_take && IN_BYTE == CMD_MEM_ACC && CHIP_INIT_LINE_N ##1 par_take && CHIP_INIT_LINE_N
      |=> MEM_ACC == $past(IN_BYTE);
  endproperty
  a_mem_acc: assert property (p_mem_acc) else $error("access mode not stored"); // R3

  property p_page_end;
    par_take && cmd_r == CMD_PAGE_ADDR && pcnt_r == 5'h01 && CHIP_INIT_LINE_N
      |=> page_end_r == $past(IN_BYTE) && state_r == ST_IDLE;
  endproperty
  a_page_end: assert property (p_page_end) else $error("page end not stored"); // R4

  property p_col_start;
    par_take && cmd_r == CMD_COL_ADDR && pcnt_r == 5'h00 && CHIP_INIT_LINE_N
      |=> col_start_r == $past(IN_BYTE) && state_r == ST_PARAM;
  endproperty
  a_col_start: assert property (p_col_start) else $error("column start not stored"); // R4

  property p_mwr_wrap;
    dat_take && col_r == col_end_r && CHIP_INIT_LINE_N |=> col_r == col_start_r;
  endproperty
  a_mwr_wrap: assert property (p_mwr_wrap) else $error("column did not wrap"); // R5

  property p_mwr_stall;
    state_r == ST_MWR && IN_DC && !buf_in_ready |-> !IN_READY && MEM_VALID;
  endproperty
  a_mwr_stall: assert property (p_mwr_stall) else $error("data taken while buffer full"); // R5

  property p_sleep;
    cmd_take && IN_BYTE == CMD_SLEEP_IN && CHIP_INIT_LINE_N |=> SLEEP_ST && !LCD_SUPPLY_EN;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep in did not stop supply"); // R9

  c_mwr_burst: cover property (dat_take [*3]);
  c_stall:     cover property (state_r == ST_MWR && IN_VALID && IN_DC && !IN_READY);
  c_disp_on:   cover property (cmd_take && IN_BYTE == CMD_DISP_ON);
  c_shutdown:  cover property (cmd_take && IN_BYTE == CMD_DISP_OFF ##[1:20] cmd_take && IN_BYTE == CMD_SLEEP_IN);

endmodule

// ===== tb/lcs_host_model.sv
// host-side model that sends command and parameter bytes to the interpreter
`timescale 1ns/1ps
module lcs_host_model
  import lcs_pkg::*;
#(
  parameter int INIT_LOW_CYC   = 120,
  parameter int SLEEP_WAIT_CYC = 40
) (
  // clock
  input  wire logic       clk,
  // byte port
  output logic            in_valid,
  input  wire logic       in_ready,
  output logic            in_dc,
  output logic [7:0]      in_byte,
  // init line
  output logic            chip_init_line_n
);
  initial begin
    in_valid         = 1'b0;
    in_dc            = 1'b0;
    in_byte          = 8'h00;
    chip_init_line_n = 1'b1;
  end

  // ------------------------------------------------------------
  // byte transfer
  // ------------------------------------------------------------
  // held until taken, so a command and its parameters go out whole
  task automatic put(input logic dc, input logic [7:0] b);
    int k;
    k = 0;
    in_valid <= 1'b1;
    in_dc    <= dc;
    in_byte  <= b;
    @(posedge clk);
    while (in_ready !== 1'b1 && k < 400) begin
      @(posedge clk);
      k++;
    end
  endtask

  // a released bus must not keep showing the last byte
  task automatic rel();
    in_valid <= 1'b0;
    in_byte  <= ~in_byte;
    in_dc    <= ~in_dc;
  endtask

  // ------------------------------------------------------------
  // shutdown sequences
  // ------------------------------------------------------------
  task automatic soft_off();
    put(1'b0, CMD_DISP_OFF);
    put(1'b0, CMD_SLEEP_IN);
    rel();
    // supply capacitors need time to drain before logic power may go
    repeat (SLEEP_WAIT_CYC) @(posedge clk);
  endtask

  task automatic hard_off();
    chip_init_line_n <= 1'b0;
    repeat (INIT_LOW_CYC) @(posedge clk);
    chip_init_line_n <= 1'b1;
  endtask
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the lcd setup and shutdown command interpreter
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top
  import lcs_pkg::*;
;
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] prm;
    logic       has;
    logic [7:0] pix;
    logic [7:0] acc;
    logic       disp;
    logic       slp;
  } lcs_row_s;

  logic        clk = 1'b0, rst = 1'b1, init_n, in_valid, in_ready, in_dc, mem_valid, mem_ready = 1'b1;
  logic [7:0]  in_byte, mem_page, mem_col, mem_data, pix_fmt, mem_acc, clr_data;
  logic [4:0]  clr_idx = 5'h00;
  logic        disp_on, sleep_st, supply_en, saw_refuse = 1'b0;
  logic [23:0] got[$];
  int          n_errors = 0, checks = 0;
  int          ix[3] = '{0, 19, 20};
  lcs_row_s    rows[7] = '{
    '{CMD_PIX_FMT,   8'h05, 1'b1, 8'h05, 8'h00, 1'b0, 1'b1},
    '{CMD_MEM_ACC,   8'hA5, 1'b1, 8'h05, 8'hA5, 1'b0, 1'b1},
    '{CMD_SLEEP_OUT, 8'h00, 1'b0, 8'h05, 8'hA5, 1'b0, 1'b0},
    '{CMD_DISP_ON,   8'h00, 1'b0, 8'h05, 8'hA5, 1'b1, 1'b0},
    '{8'h55,         8'h00, 1'b0, 8'h05, 8'hA5, 1'b1, 1'b0},
    '{CMD_PIX_FMT,   8'h02, 1'b1, 8'h02, 8'hA5, 1'b1, 1'b0},
    '{CMD_MEM_ACC,   8'hA5, 1'b1, 8'h02, 8'hA5, 1'b1, 1'b0}};

  always #12.5 clk = ~clk;

  lcs_cmd_interp dut_u (.CLK(clk), .RST(rst), .CHIP_INIT_LINE_N(init_n), .IN_VALID(in_valid),
    .IN_READY(in_ready), .IN_DC(in_dc), .IN_BYTE(in_byte), .MEM_VALID(mem_valid), .MEM_READY(mem_ready),
    .MEM_PAGE(mem_page), .MEM_COL(mem_col), .MEM_DATA(mem_data), .PIX_FMT(pix_fmt), .MEM_ACC(mem_acc),
    .CLR_RD_IDX(clr_idx), .CLR_RD_DATA(clr_data), .DISP_ON(disp_on), .SLEEP_ST(sleep_st),
    .LCD_SUPPLY_EN(supply_en));

  lcs_host_model host_u (.clk(clk), .in_valid(in_valid), .in_ready(in_ready), .in_dc(in_dc),
    .in_byte(in_byte), .chip_init_line_n(init_n));

  // ------------------------------------------------------------
  // memory sink and refusal watch
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (mem_valid && mem_ready)
      got.push_back({mem_page, mem_col, mem_data});
    if (in_valid && !in_ready)
      saw_refuse = 1'b1;
  end

  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic cmd(input logic [7:0] c, input logic [7:0] a, input logic [7:0] b, input int n);
    host_u.put(1'b0, c);
    if (n > 0) host_u.put(1'b1, a);
    if (n > 1) host_u.put(1'b1, b);
  endtask

  task automatic cfg(input logic [7:0] p, input logic [7:0] a, input logic d, input logic s);
    #1;
    `CHK("pix_fmt", p, pix_fmt)
    `CHK("mem_acc", a, mem_acc)
    `CHK("disp_on", d, disp_on)
    `CHK("sleep_st", s, sleep_st)
    `CHK("supply_en", ~s, supply_en)
    @(posedge clk);
  endtask

  task automatic end_of_test();
    if (n_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    w(12);
    rst <= 1'b0;
    w(1);
    cfg(PIX_FMT_RST, MEM_ACC_RST, 1'b0, 1'b1);
    foreach (rows[i]) begin
      cmd(rows[i].cmd, rows[i].prm, 8'h00, int'(rows[i].has));
      host_u.rel();
      w(2);
      cfg(rows[i].pix, rows[i].acc, rows[i].disp, rows[i].slp);
    end
    host_u.soft_off();
    w(2);
    cfg(8'h02, 8'hA5, 1'b0, 1'b1);
    // colour table: 20 entries, one past the end reads zero
    cmd(CMD_CLR_SET, 8'h00, 8'h00, 0);
    for (int i = 0; i < CLR_SET_LEN; i++) host_u.put(1'b1, 8'(i * 11 + 3));
    host_u.rel();
    foreach (ix[j]) begin
      clr_idx <= 5'(ix[j]);
      w(2);
      #1;
      `CHK("clr_data", (ix[j] < CLR_SET_LEN) ? 8'(ix[j] * 11 + 3) : 8'h00, clr_data)
      @(posedge clk);
    end
    // window and memory write with the sink stalled for 30 cycles so the buffer refuses
    mem_ready <= 1'b0;
    fork
      begin
        cmd(CMD_PAGE_ADDR, 8'h01, 8'h02, 2);
        cmd(CMD_COL_ADDR, 8'h05, 8'h06, 2);
        cmd(CMD_MEM_WR, 8'h00, 8'h00, 0);
        for (int i = 0; i < 5; i++) host_u.put(1'b1, 8'(8'hE0 + i));
        host_u.rel();
      end
      begin
        w(30);
        mem_ready <= 1'b1;
      end
    join
    w(20);
    #1;
    `CHK("refused", 1'b1, saw_refuse)
    `CHK("drained", 1'b0, mem_valid)
    `CHK("words", 5, got.size())
    for (int i = 0; i < 5 && i < got.size(); i++)
      `CHK("mem_word", ({8'(1 + (i / 2) % 2), 8'(5 + i % 2), 8'(8'hE0 + i)}), got[i])
    @(posedge clk);
    // shutdown through the init line brings every setting back
    host_u.hard_off();
    w(2);
    cfg(PIX_FMT_RST, MEM_ACC_RST, 1'b0, 1'b1);
    end_of_test();
  end

  initial begin
    w(5000);
    n_errors++;
    end_of_test();
  end
endmodule
